// ===== hdl/channel_status_flags.sv
// Behaviour
// - Bit 0 low while command runs
// - Bit 1 gives command pass or fail
// - Finished command returns to imaging, sets done
// - Download with unchanged database never passes
// - Bit 2 toggles on each new primary value
// - Bit 3 shows forced output mode
// - Bit 4 flags handheld change, feeds mismatch
// - Bit 5 toggles on each new secondary value
// - Bit 6 toggles on complete database only
// - Bit 8 shows cold junction reference choice
// - Bit 9 shows open thermocouple detection enabled
// - Bit 10 shows 50 Hz filter setting
// - Bit 11 follows any active database mismatch
// - Bit 13 flags suspect primary value
// - Refresh timeout sets bad value
// - Lost termination or power sets bad value
// - Handheld or partner write sets bad value
// - Database mismatch sets bad value
// - Bit 14 flags value below range
// - Bit 15 flags value above range
// - Mismatch clears on upload or readback after good download
`timescale 1ns/100ps
`default_nettype none
module channel_status_flags
    import status_flags_pkg::*;
#(
    parameter logic [5:0] CHANNEL_ID = CHANNEL_ID_DEFAULT,
    parameter int unsigned PV_TIMEOUT_CYCLES = PV_TIMEOUT_CYC
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic block_read_transfer, // Host read strobe, one cycle
    input wire logic block_write_transfer, // Host write strobe, one cycle
    input wire logic [5:0] block_id, // Block identifier of the transfer
    input wire logic [3:0] func_code, // Command code carried by a write
    input wire logic cmd_finish, // Instrument engine ends a download
    input wire logic cmd_ok, // Outcome qualifier for cmd_finish
    input wire logic db_changed, // Some database parameter differs
    input wire logic pv_new, // New primary value received, pulse
    input wire logic sv_new, // New secondary value received, pulse
    input wire logic db_complete, // Whole database received, pulse
    input wire logic mismatch_detect, // Comparator found a mismatch, pulse
    input wire logic hh_write_detect, // Handheld changed parameters, pulse
    input wire logic partner_download, // Partner module downloaded, pulse
    input wire logic forced_output, // Instrument in forced output mode
    input wire logic cold_junction_internal, // Internal reference in use
    input wire logic open_tc_enable, // Open thermocouple detection on
    input wire logic filter_50hz, // 50 Hz mains filter selected
    input wire logic pv_under, // Value below 0% of range
    input wire logic pv_over, // Value above 100% of range
    input wire logic field_termination_assembly_present, // Connector pin
    input wire logic field_power_ok, // Field supply pin
    output logic [15:0] status_word, // Word presented to the host
    output logic download_req, // Download to the instrument running
    output logic cmd_busy // Any command running
);

    localparam int unsigned TW = $clog2(PV_TIMEOUT_CYCLES + 1);
    localparam logic [TW-1:0] TMO_LIMIT = TW'(PV_TIMEOUT_CYCLES);

    // Whole state of the channel in one record
    typedef struct packed {
        cmd_state_t mode; // Command sequencer
        logic [3:0] func; // Command being run
        logic done; // Completion flag
        logic passed; // Outcome flag
        logic pv_tog; // Primary value toggle
        logic sv_tog; // Secondary value toggle
        logic db_tog; // Database toggle
        logic hh_seen; // Handheld change seen
        logic mismatch; // Database mismatch active
        logic clr_wait; // Download done, waiting for readback
        logic hh_bad; // Foreign write makes value suspect
        logic tmo; // Refresh timeout reached
        logic [TW-1:0] tmo_cnt; // Cycles since last primary value
        logic [15:0] word; // Presented status word
        logic busy; // Command running, drives cmd_busy
        logic dl_req; // Download running, drives download_req
    } chan_state_t;

    localparam chan_state_t RST_STATE = '{
        mode: ST_IMAGING,
        func: FUNC_IMAGING,
        done: 1'b1,
        word: STATUS_RESET,
        default: '0
    };

    chan_state_t st_r; // Registered state
    chan_state_t st_nxt; // Next state
    logic [1:0] pins; // Filtered connector and power levels
    logic rd_hit; // Read transfer for this channel
    logic wr_hit; // Write transfer for this channel
    logic cmd_go; // A new command is accepted
    logic upload_go; // Host upload accepted
    logic mm_set; // Mismatch cause this cycle
    logic bad_now; // Bad value condition this cycle

    // Connector and power pins come from outside the clock domain
    pin_sync #(
        .W(2)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d({field_power_ok, field_termination_assembly_present}),
        .q(pins)
    );

    // Transfer decode by block identifier
    always_comb begin
        rd_hit = block_read_transfer && (block_id == CHANNEL_ID);
        wr_hit = block_write_transfer && (block_id == CHANNEL_ID);
        // Commands are only taken while imaging; later writes are ignored
        cmd_go = wr_hit && (st_r.mode == ST_IMAGING) && (func_code != FUNC_IMAGING);
        upload_go = cmd_go && (func_code == FUNC_UPLOAD);
        mm_set = mismatch_detect || hh_write_detect;
    end

    // Next state of the whole channel
    always_comb begin
        st_nxt = st_r;

        // Command sequencer
        case (st_r.mode)
            ST_IMAGING: begin
                if (cmd_go) begin
                    st_nxt.func = func_code;
                    st_nxt.done = 1'b0;
                    st_nxt.passed = 1'b0;
                    if (func_code == FUNC_UPLOAD) begin
                        // Host copies the database itself; nothing to wait for
                        st_nxt.done = 1'b1;
                        st_nxt.passed = 1'b1;
                        st_nxt.func = FUNC_IMAGING;
                    end else if (func_code == FUNC_DOWNLOAD) begin
                        st_nxt.mode = ST_BUSY;
                    end else begin
                        // Unsupported codes finish at once as failed
                        st_nxt.done = 1'b1;
                        st_nxt.func = FUNC_IMAGING;
                    end
                end
            end
            ST_BUSY: begin
                if (cmd_finish) begin
                    st_nxt.mode = ST_IMAGING;
                    st_nxt.func = FUNC_IMAGING;
                    st_nxt.done = 1'b1;
                    // An unchanged database never reports success
                    st_nxt.passed = cmd_ok && db_changed;
                    st_nxt.clr_wait = cmd_ok && db_changed;
                end
            end
            default: begin
                st_nxt.mode = ST_IMAGING;
            end
        endcase

        // Output flags kept in the state register so the pins carry no decode
        st_nxt.busy = (st_nxt.mode == ST_BUSY);
        st_nxt.dl_req = (st_nxt.mode == ST_BUSY) && (st_nxt.func == FUNC_DOWNLOAD);

        // Toggles; two arrivals between reads cancel, which the host accepts
        if (pv_new) begin
            st_nxt.pv_tog = !st_r.pv_tog;
        end
        if (sv_new) begin
            st_nxt.sv_tog = !st_r.sv_tog;
        end
        if (db_complete) begin
            st_nxt.db_tog = !st_r.db_tog;
        end

        // Mismatch: clears on upload, or on readback after a good download
        if (upload_go) begin
            st_nxt.mismatch = 1'b0;
            st_nxt.clr_wait = 1'b0;
            st_nxt.hh_seen = 1'b0;
        end else if (st_r.clr_wait && db_complete) begin
            st_nxt.mismatch = 1'b0;
            st_nxt.clr_wait = 1'b0;
            st_nxt.hh_seen = 1'b0;
        end
        // A new cause wins over a clear in the same cycle
        if (mm_set) begin
            st_nxt.mismatch = 1'b1;
        end
        if (hh_write_detect) begin
            st_nxt.hh_seen = 1'b1;
        end

        // A foreign write keeps the value suspect until it is refreshed
        if (pv_new) begin
            st_nxt.hh_bad = 1'b0;
        end
        if (hh_write_detect || partner_download) begin
            st_nxt.hh_bad = 1'b1;
        end

        // Refresh timeout counter saturates at the limit
        if (pv_new) begin
            st_nxt.tmo_cnt = '0;
            st_nxt.tmo = 1'b0;
        end else if (st_r.tmo_cnt != TMO_LIMIT) begin
            st_nxt.tmo_cnt = st_r.tmo_cnt + 1'b1;
            st_nxt.tmo = (st_r.tmo_cnt + 1'b1) == TMO_LIMIT;
        end

        // Word is captured at each read transfer of this channel
        if (rd_hit) begin
            st_nxt.word[BIT_DONE] = st_r.done;
            st_nxt.word[BIT_PASSED] = st_r.passed;
            st_nxt.word[BIT_PV_TOGGLE] = st_r.pv_tog;
            st_nxt.word[BIT_FORCED_OUT] = forced_output;
            st_nxt.word[BIT_HH_CHANGED] = st_r.hh_seen;
            st_nxt.word[BIT_SV_TOGGLE] = st_r.sv_tog;
            st_nxt.word[BIT_DB_TOGGLE] = st_r.db_tog;
            st_nxt.word[BIT_SPARE_LO] = 1'b0;
            st_nxt.word[BIT_COLD_JUNC] = cold_junction_internal;
            st_nxt.word[BIT_OPEN_TC] = open_tc_enable;
            st_nxt.word[BIT_FILTER_50] = filter_50hz;
            st_nxt.word[BIT_MISMATCH] = st_r.mismatch;
            st_nxt.word[BIT_SPARE_HI] = 1'b0;
            st_nxt.word[BIT_BAD_PV] = bad_now;
            st_nxt.word[BIT_UNDER] = pv_under;
            st_nxt.word[BIT_OVER] = pv_over;
        end
    end

    // Bad value summary, clears by itself once every cause is gone
    always_comb begin
        bad_now = st_r.tmo
            || !pins[0] || !pins[1]
            || st_r.hh_bad
            || st_r.mismatch;
    end

    // The one state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= RST_STATE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign status_word = st_r.word;
    assign download_req = st_r.dl_req;
    assign cmd_busy = st_r.busy;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Done stays low for the whole download
    a_done_low_busy: assert property (
        (st_r.mode == ST_BUSY) |-> !st_r.done
    ) else $error("done set while command busy");

    // Finish returns to imaging with done set
    a_finish_to_imaging: assert property (
        (ce && st_r.mode == ST_BUSY && cmd_finish) |=> (st_r.mode == ST_IMAGING && st_r.done)
    ) else $error("finish did not return to imaging");

    // Outcome follows the instrument result
    a_pass_outcome: assert property (
        (ce && st_r.mode == ST_BUSY && cmd_finish && !cmd_ok) |=> !st_r.passed
    ) else $error("failed command reported passed");

    // Unchanged database download never passes
    a_no_change_fail: assert property (
        (ce && st_r.mode == ST_BUSY && cmd_finish && !db_changed) |=> !st_r.passed
    ) else $error("download without change passed");

    // Primary value toggle flips once per arrival
    a_pv_flip: assert property (
        (ce && pv_new) |=> (st_r.pv_tog != $past(st_r.pv_tog))
    ) else $error("primary toggle did not flip");

    // Spare bits never set
    a_spare_zero: assert property (
        !status_word[BIT_SPARE_LO] && !status_word[BIT_SPARE_HI]
    ) else $error("spare status bit set");

    // Mismatch only falls on upload or readback after download
    a_mm_clear_cause: assert property (
        $fell(st_r.mismatch) |-> ($past(upload_go) || ($past(st_r.clr_wait) && $past(db_complete)))
    ) else $error("mismatch cleared without cause");

    // Mismatch shows as a bad value at the next read
    a_bad_on_mismatch: assert property (
        (ce && rd_hit && st_r.mismatch) |=> (status_word[BIT_BAD_PV] && status_word[BIT_MISMATCH])
    ) else $error("mismatch not reported as bad value");

    // Timeout flag rises when the counter reaches the limit
    a_timeout_set: assert property (
        (ce && !pv_new && st_r.tmo_cnt == TMO_LIMIT - 1'b1) |=> st_r.tmo
    ) else $error("refresh timeout not flagged");

    // Range flags are copied at the read
    a_range_copy: assert property (
        (ce && rd_hit) |=> (status_word[BIT_UNDER] == $past(pv_under)
            && status_word[BIT_OVER] == $past(pv_over))
    ) else $error("range flags not captured");

    // Secondary value toggle flips once per arrival
    a_sv_flip: assert property (
        (ce && sv_new) |=> (st_r.sv_tog != $past(st_r.sv_tog))
    ) else $error("secondary toggle did not flip");

    // Database toggle moves on a complete database and at no other time
    a_db_flip_only: assert property (
        ce |=> ((st_r.db_tog != $past(st_r.db_tog)) == $past(db_complete))
    ) else $error("database toggle out of step");

    // Handheld change marks bit 4 and raises the mismatch
    a_hh_feeds_mm: assert property (
        (ce && hh_write_detect) |=> (st_r.hh_seen && st_r.mismatch)
    ) else $error("handheld change not flagged");

    // Handheld or partner write makes the value suspect
    a_foreign_bad: assert property (
        (ce && (hh_write_detect || partner_download)) |=> st_r.hh_bad
    ) else $error("foreign write not marked bad");

    // Upload finishes at once as passed; a new cause in that cycle still wins
    a_upload_done: assert property (
        (ce && upload_go && !mm_set) |=> (st_r.done && st_r.passed && !st_r.mismatch)
    ) else $error("upload did not finish cleanly");

    // Configuration levels are copied at the read
    a_cfg_copy: assert property (
        (ce && rd_hit) |=> (status_word[BIT_COLD_JUNC] == $past(cold_junction_internal)
            && status_word[BIT_OPEN_TC] == $past(open_tc_enable)
            && status_word[BIT_FILTER_50] == $past(filter_50hz))
    ) else $error("configuration flags not captured");

    // A missing connector or field supply reads as a bad value
    a_pin_bad: assert property (
        (ce && rd_hit && !(pins[0] && pins[1])) |=> status_word[BIT_BAD_PV]
    ) else $error("lost connector not reported as bad value");

endmodule
`default_nettype wire

// ===== hdl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import status_flags_pkg::*;
#(
    parameter int unsigned W = 2
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] d, // Raw pin levels
    output logic [W-1:0] q // Filtered levels
);

    // Three stages plus the accepted value
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] acc;
    } sync_t;

    sync_t st_r; // Registered state
    sync_t st_nxt; // Next state

    // Shift chain; a change counts only when stages two and three agree,
    // and stage one is read by stage two alone to keep metastability away
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.acc[i] = st_r.s3[i];
            end
        end
    end

    // Pins assumed present at reset so a clean start shows no fault
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{default: '1};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.acc;

endmodule
`default_nettype wire

// ===== shared/status_flags_pkg.sv
package status_flags_pkg;

    // Bit positions inside the channel status word
    localparam int unsigned BIT_DONE = 0;
    localparam int unsigned BIT_PASSED = 1;
    localparam int unsigned BIT_PV_TOGGLE = 2;
    localparam int unsigned BIT_FORCED_OUT = 3;
    localparam int unsigned BIT_HH_CHANGED = 4;
    localparam int unsigned BIT_SV_TOGGLE = 5;
    localparam int unsigned BIT_DB_TOGGLE = 6;
    localparam int unsigned BIT_SPARE_LO = 7;
    localparam int unsigned BIT_COLD_JUNC = 8;
    localparam int unsigned BIT_OPEN_TC = 9;
    localparam int unsigned BIT_FILTER_50 = 10;
    localparam int unsigned BIT_MISMATCH = 11;
    localparam int unsigned BIT_SPARE_HI = 12;
    localparam int unsigned BIT_BAD_PV = 13;
    localparam int unsigned BIT_UNDER = 14;
    localparam int unsigned BIT_OVER = 15;

    // Status word after reset: no command pending, so the done bit reads 1
    localparam logic [15:0] STATUS_RESET = 16'h0001;

    // Channel command codes written by the host
    localparam logic [3:0] FUNC_IMAGING = 4'h0;
    localparam logic [3:0] FUNC_DOWNLOAD = 4'h1;
    localparam logic [3:0] FUNC_UPLOAD = 4'h2;

    // Primary value refresh timeout, and its length in clock cycles
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned PV_TIMEOUT_MS = 1000;
    localparam int unsigned PV_TIMEOUT_CYC = (CLK_HZ / 1000) * PV_TIMEOUT_MS;

    // Default block identifier of this channel
    localparam logic [5:0] CHANNEL_ID_DEFAULT = 6'h01;

    // Channel command sequencer
    typedef enum logic {
        ST_IMAGING,
        ST_BUSY
    } cmd_state_t;

endpackage

// ===== verification/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
    import status_flags_pkg::*;
(
    input wire logic clk, // Bench clock
    output logic block_read_transfer, // Read strobe
    output logic block_write_transfer, // Write strobe
    output logic [5:0] block_id, // Block identifier
    output logic [3:0] func_code // Command code
);
    // Released lines carry the inverse of their last value, so a stale copy never matches
    initial begin
        block_read_transfer = 1'b0;
        block_write_transfer = 1'b0;
        block_id = 6'h3e;
        func_code = 4'hf;
    end

    // One read strobe, held for exactly one sampling edge
    task automatic read_blk(input logic [5:0] id);
        @(negedge clk);
        block_read_transfer = 1'b1;
        block_id = id;
        @(negedge clk);
        block_read_transfer = 1'b0;
        block_id = ~id;
    endtask

    // One command write: code 0 images, 1 downloads, 2 uploads
    task automatic write_cmd(input logic [5:0] id, input logic [3:0] code);
        @(negedge clk);
        block_write_transfer = 1'b1;
        block_id = id;
        func_code = code;
        @(negedge clk);
        block_write_transfer = 1'b0;
        block_id = ~id;
        func_code = ~code;
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import status_flags_pkg::*;
    localparam logic [5:0] CHID = 6'h05; // Non-default channel, so the id compare is exercised
    localparam int unsigned TMO = 16; // Shortened refresh timeout keeps the run brief
    logic clk = 1'b0; // 25 MHz clock
    logic rst = 1'b1; // Reset, held at start
    logic ce = 1'b1; // Clock enable, dropped once to test the freeze
    logic [6:0] ev = 7'h00; // Pulses: pv, sv, db, mismatch, handheld, partner, finish
    logic cmd_ok = 1'b0; // Outcome qualifier
    logic db_changed = 1'b0; // Database changed qualifier
    logic [5:0] lv = 6'h00; // Levels: forced, cold junction, open tc, 50 Hz, under, over
    logic term_ok = 1'b1; // Termination connector present
    logic pwr_ok = 1'b1; // Field power present
    logic brt; // Read strobe from host
    logic bwt; // Write strobe from host
    logic [5:0] bid; // Block id from host
    logic [3:0] fc; // Command code from host
    logic [15:0] status_word; // Word under test
    logic download_req; // Download running
    logic cmd_busy; // Command running
    logic [31:0] rnd = 32'h1ae00fb6; // Random source
    logic pv_t = 1'b0; // Expected toggle states
    logic sv_t = 1'b0;
    logic db_t = 1'b0;
    logic done = 1'b1; // Expected command flags
    logic passed = 1'b0;
    logic hh = 1'b0; // Expected handheld and mismatch flags
    logic mm = 1'b0;
    logic badx = 1'b0; // Bad value from causes other than mismatch
    logic hit_d = 1'b0; // A read hit was taken at the last edge
    logic [31:0] q_w[$]; // Notes of {mask, word}
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;

    // Free-running clock
    always #20 clk = ~clk;

    host_model host (.clk(clk), .block_read_transfer(brt), .block_write_transfer(bwt),
        .block_id(bid), .func_code(fc));

    channel_status_flags #(.CHANNEL_ID(CHID), .PV_TIMEOUT_CYCLES(TMO)) DUT (
        .clk(clk), .rst(rst), .ce(ce), .block_read_transfer(brt),
        .block_write_transfer(bwt), .block_id(bid), .func_code(fc), .cmd_finish(ev[6]),
        .cmd_ok(cmd_ok), .db_changed(db_changed), .pv_new(ev[0]), .sv_new(ev[1]),
        .db_complete(ev[2]), .mismatch_detect(ev[3]), .hh_write_detect(ev[4]),
        .partner_download(ev[5]), .forced_output(lv[0]), .cold_junction_internal(lv[1]),
        .open_tc_enable(lv[2]), .filter_50hz(lv[3]), .pv_under(lv[4]), .pv_over(lv[5]),
        .field_termination_assembly_present(term_ok), .field_power_ok(pwr_ok),
        .status_word(status_word), .download_req(download_req), .cmd_busy(cmd_busy));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected word built from the bench's own view of the channel
    function automatic logic [15:0] expw();
        return {lv[5], lv[4], mm | badx, 1'b0, mm, lv[3], lv[2], lv[1],
            1'b0, db_t, sv_t, hh, lv[0], pv_t, passed, done};
    endfunction

    // Masked compare; masking lets a busy read check only the done bit
    task automatic chk(input logic [15:0] got, input logic [31:0] e);
        tests_run++;
        if ((got & e[31:16]) !== (e[15:0] & e[31:16])) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, e[15:0]);
        end
    endtask

    // One-cycle event pulses; toggle expectations follow each arrival
    task automatic fire(input logic [6:0] m);
        @(negedge clk);
        ev = m;
        pv_t ^= m[0];
        sv_t ^= m[1];
        db_t ^= m[2];
        @(negedge clk);
        ev = 7'h00;
    endtask

    // Read with random levels; a fresh value first keeps the timeout away
    task automatic rd(input logic pv, input logic [15:0] m);
        if (pv) fire(7'h01);
        rnd = lfsr(rnd);
        lv = rnd[5:0];
        q_w.push_back({m, expw()});
        host.read_blk(CHID);
    endtask

    task automatic finish_cmd(input logic ok, input logic chg);
        cmd_ok = ok;
        db_changed = chg;
        fire(7'h40);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Note which edges took a read hit, and count cycles for the hang limit
    always @(posedge clk) begin
        hit_d <= (brt === 1'b1) && (bid === CHID) && (ce === 1'b1);
        cyc <= cyc + 1;
    end

    // The word is settled by the falling edge after a hit; match it to the oldest note
    always @(negedge clk) begin
        if (hit_d) begin
            if (q_w.size() == 0) begin
                n_fail++;
                $display("[ERR] %0t unexpected word", $time);
            end else begin
                chk(status_word, q_w.pop_front());
            end
        end
        if (cyc > 3000) begin
            n_fail++;
            $display("[ERR] %0t run too long", $time);
            complete_run();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd(1'b1, 16'hffff);
        host.read_blk(6'h09);
        chk(status_word, {16'hffff, expw()});
        for (int i = 0; i < 12; i++) begin
            fire({5'h00, rnd[9], 1'b0});
            rd(1'b1, 16'hffff);
        end
        host.write_cmd(CHID, FUNC_DOWNLOAD);
        chk({14'h0, download_req, cmd_busy}, {16'h0003, 16'h0003});
        done = 1'b0;
        rd(1'b1, 16'h0001);
        finish_cmd(1'b1, 1'b1);
        done = 1'b1;
        passed = 1'b1;
        rd(1'b1, 16'hffff);
        chk({14'h0, download_req, cmd_busy}, {16'h0003, 16'h0000});
        host.write_cmd(CHID, FUNC_DOWNLOAD);
        finish_cmd(1'b1, 1'b0);
        passed = 1'b0;
        rd(1'b1, 16'hffff);
        host.write_cmd(CHID, FUNC_UPLOAD);
        passed = 1'b1;
        rd(1'b1, 16'hffff);
        host.write_cmd(CHID, FUNC_IMAGING);
        rd(1'b1, 16'hffff);
        host.write_cmd(CHID, 4'h3);
        passed = 1'b0;
        rd(1'b1, 16'hffff);
        fire(7'h08);
        mm = 1'b1;
        rd(1'b1, 16'hffff);
        host.write_cmd(CHID, FUNC_UPLOAD);
        mm = 1'b0;
        passed = 1'b1;
        rd(1'b1, 16'hffff);
        host.write_cmd(CHID, FUNC_DOWNLOAD);
        finish_cmd(1'b0, 1'b1);
        passed = 1'b0;
        rd(1'b1, 16'hffff);
        fire(7'h10);
        hh = 1'b1;
        mm = 1'b1;
        rd(1'b1, 16'hffff);
        host.write_cmd(CHID, FUNC_DOWNLOAD);
        finish_cmd(1'b1, 1'b1);
        passed = 1'b1;
        rd(1'b1, 16'hffff);
        fire(7'h04);
        mm = 1'b0;
        hh = 1'b0;
        rd(1'b1, 16'hffff);
        fire(7'h20);
        badx = 1'b1;
        rd(1'b0, 16'hffff);
        badx = 1'b0;
        rd(1'b1, 16'hffff);
        repeat (TMO + 4) @(negedge clk);
        badx = 1'b1;
        rd(1'b0, 16'hffff);
        badx = 1'b0;
        rd(1'b1, 16'hffff);
        pwr_ok = 1'b0;
        repeat (6) @(negedge clk);
        badx = 1'b1;
        rd(1'b1, 16'hffff);
        pwr_ok = 1'b1;
        term_ok = 1'b0;
        repeat (6) @(negedge clk);
        rd(1'b1, 16'hffff);
        term_ok = 1'b1;
        repeat (6) @(negedge clk);
        badx = 1'b0;
        rd(1'b1, 16'hffff);
        // Clock enable low: a matching read with new levels must leave the word alone
        ce = 1'b0;
        lv = ~lv;
        host.read_blk(CHID);
        ce = 1'b1;
        lv = ~lv;
        chk(status_word, {16'hffff, expw()});
        repeat (4) @(negedge clk);
        if (q_w.size() != 0) begin
            n_fail++;
            $display("[ERR] %0t expected words left unread", $time);
        end
        complete_run();
    end
endmodule
`default_nettype wire
